// ### tap_pkg.sv
// Constants and types for the test access port controller
`default_nettype none

package tap_pkg;

  typedef enum logic [3:0] {
    TLR        = 4'h0,
    RUN_IDLE   = 4'h1,
    SEL_DR     = 4'h3,
    CAP_DR     = 4'h2,
    SHIFT_DR   = 4'h6,
    EXIT1_DR   = 4'h7,
    PAUSE_DR   = 4'h5,
    EXIT2_DR   = 4'h4,
    UPDATE_DR  = 4'hC,
    SEL_IR     = 4'hD,
    CAP_IR     = 4'hF,
    SHIFT_IR   = 4'hE,
    EXIT1_IR   = 4'hA,
    PAUSE_IR   = 4'hB,
    EXIT2_IR   = 4'h9,
    UPDATE_IR  = 4'h8
  } tap_state_t;

  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hF;
  // Fixed capture pattern, low two bits per convention
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  // Arbitrary identification value, names no real part
  localparam logic [ID_W-1:0] ID_VALUE_DEFAULT = 32'h0000_0001;

endpackage : tap_pkg

`default_nettype wire

// ### tap_port.sv
// Test access port controller sampled by the core clock
`default_nettype none

module tap_port
  import tap_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEFAULT
)
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // Current instruction for the rest of the device
  output logic [IR_W-1:0] instr
);

  logic [2:0] tck_sync_reg;
  logic [1:0] tms_sync_reg;
  logic [1:0] tdi_sync_reg;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  tap_state_t state_reg;
  tap_state_t state_next;
  logic [IR_W-1:0] ir_shift_reg;
  logic [IR_W-1:0] ir_reg;
  logic [ID_W-1:0] id_shift_reg;
  logic bypass_reg;
  logic tdo_reg;
  logic oe_reg;
  logic shifting;
  logic out_bit;
  logic [1:0] trst_sync_reg;
  logic trst_done;

  function automatic tap_state_t tap_step(input tap_state_t s, input logic m);
    tap_state_t n;
    n = s;
    unique case (s)
      TLR:       n = m ? TLR : RUN_IDLE;
      RUN_IDLE:  n = m ? SEL_DR : RUN_IDLE;
      SEL_DR:    n = m ? SEL_IR : CAP_DR;
      CAP_DR:    n = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:  n = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:  n = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:  n = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:  n = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: n = m ? SEL_DR : RUN_IDLE;
      SEL_IR:    n = m ? TLR : CAP_IR;
      CAP_IR:    n = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:  n = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:  n = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:  n = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:  n = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: n = m ? SEL_DR : RUN_IDLE;
    endcase
    return n;
  endfunction : tap_step

  // Pin synchronisers; equal depth keeps tms and tdi aligned with the tck edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tck_sync_reg <= 3'h0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h3;
    end
    else
    begin
      tck_sync_reg <= {tck_sync_reg[1:0], tck};
      tms_sync_reg <= {tms_sync_reg[0], tms};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi};
    end
  end

  assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
  assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
  assign tms_s = tms_sync_reg[1];
  assign tdi_s = tdi_sync_reg[1];
  assign state_next = tap_step(state_reg, tms_s);

  // Test reset clears at once but is let go on the core clock, avoiding a late recovery
  always_ff @(posedge core_clk or negedge trst_n)
  begin
    if (!trst_n)
      trst_sync_reg <= 2'h0;
    else
      trst_sync_reg <= {trst_sync_reg[0], 1'b1};
  end

  assign trst_done = trst_sync_reg[1];

  // Test reset acts without waiting for any clock
  always_ff @(posedge core_clk or negedge trst_n)
  begin
    if (!trst_n)
      state_reg <= TLR;
    else if (rst || !trst_done)
      state_reg <= TLR;
    else if (tck_rise)
      state_reg <= state_next;
  end

  // Shift paths advance only on test clock rising edges
  always_ff @(posedge core_clk or negedge trst_n)
  begin
    if (!trst_n)
    begin
      ir_shift_reg <= IR_CAPTURE;
      ir_reg <= INSTR_IDCODE;
      id_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end
    else if (rst || !trst_done)
    begin
      ir_shift_reg <= IR_CAPTURE;
      ir_reg <= INSTR_IDCODE;
      id_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end
    else if (tck_rise)
    begin
      unique case (state_reg)
        TLR:
          ir_reg <= INSTR_IDCODE;
        CAP_IR:
          ir_shift_reg <= IR_CAPTURE;
        SHIFT_IR:
          ir_shift_reg <= {tdi_s, ir_shift_reg[IR_W-1:1]};
        UPDATE_IR:
          ir_reg <= ir_shift_reg;
        CAP_DR:
        begin
          id_shift_reg <= ID_VALUE;
          bypass_reg <= 1'b0;
        end
        SHIFT_DR:
        begin
          id_shift_reg <= {tdi_s, id_shift_reg[ID_W-1:1]};
          bypass_reg <= tdi_s;
        end
        default:
        begin
          ir_reg <= ir_reg;
        end
      endcase
    end
  end

  assign shifting = (state_reg == SHIFT_IR) || (state_reg == SHIFT_DR);
  assign out_bit = (state_reg == SHIFT_IR) ? ir_shift_reg[0] :
                   (ir_reg == INSTR_IDCODE) ? id_shift_reg[0] : bypass_reg;

  // Output data and enable move on falling edges so the tester samples a settled bit
  always_ff @(posedge core_clk or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (rst || !trst_done)
    begin
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_reg <= out_bit;
      oe_reg <= shifting;
    end
  end

  assign tdo = tdo_reg;
  // Gated by state too, so the pin floats as soon as the shift state is left
  assign tdo_oe = oe_reg & shifting;
  assign instr = ir_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !trst_n);

  sequence rise_in_idle_s;
    tck_rise && state_reg == RUN_IDLE;
  endsequence

  sequence fall_in_shift_ir_s;
    tck_fall && state_reg == SHIFT_IR;
  endsequence

  sequence fall_in_shift_dr_s;
    tck_fall && state_reg == SHIFT_DR;
  endsequence

  sequence rise_leaving_shift_s;
    tck_rise && shifting && tms_s;
  endsequence

  oe_shift_only_a: assert property (tdo_oe |-> state_reg inside {SHIFT_IR, SHIFT_DR})
    else $error("tdo driven outside shift states");

  tdo_on_fall_a: assert property ($changed(tdo) |-> $past(tck_fall))
    else $error("tdo changed without a falling test clock");

  state_on_rise_a: assert property ($changed(state_reg) |-> $past(tck_rise))
    else $error("state moved without a rising test clock");

  idle_tms_step_a: assert property (rise_in_idle_s |=> state_reg == (tms_s ? SEL_DR : RUN_IDLE))
    else $error("wrong step out of run-idle");

  trst_forces_a: assert property (@(posedge core_clk) disable iff (rst)
    !trst_n |-> state_reg == TLR && !tdo_oe)
    else $error("test reset did not force reset state");

  bypass_tdi_a: assert property (tck_rise && state_reg == SHIFT_DR |=> bypass_reg == $past(tdi_s))
    else $error("bypass did not take tdi");

  reset_hold_a: assert property (tck_rise && state_reg == TLR && tms_s |=> state_reg == TLR)
    else $error("reset state not held with tms high");

  ir_out_bit_a: assert property (fall_in_shift_ir_s |=> tdo == $past(ir_shift_reg[0]) && tdo_oe)
    else $error("instruction bit not presented on tdo");

  dr_out_bit_a: assert property (fall_in_shift_dr_s |=> tdo_oe &&
    tdo == ((ir_reg == INSTR_IDCODE) ? $past(id_shift_reg[0]) : $past(bypass_reg)))
    else $error("data register bit not presented on tdo");

  oe_exit_drop_a: assert property (rise_leaving_shift_s |=> !tdo_oe)
    else $error("tdo still driven after leaving shift state");

  trst_release_a: assert property (!trst_done |-> state_reg == TLR && !tdo_oe)
    else $error("controller left reset state before test reset release settled");

endmodule : tap_port

`default_nettype wire

// ### jtag_tester.sv
// Tester model driving the test port pins
`default_nettype none
module jtag_tester
(
  // Clock
  input wire logic core_clk,
  // Test port pins
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end
  // Pins change mid low phase, far from the rise, so the synchroniser sees them settled
  task automatic step(input logic m, input logic d, output logic q, output logic q2);
    @(negedge core_clk);
    tms = m;
    tdi = d;
    repeat (8) @(negedge core_clk);
    q = tdo_oe ? tdo : 1'bz;
    tck = 1'b1;
    repeat (16) @(negedge core_clk);
    q2 = tdo_oe ? tdo : 1'bz;
    tck = 1'b0;
    repeat (7) @(negedge core_clk);
  endtask : step
  // Test reset moves only at a falling core clock edge, like every other pin
  task automatic set_trst(input logic v);
    @(negedge core_clk);
    trst_n = v;
  endtask : set_trst
endmodule : jtag_tester
`default_nettype wire

// ### jtag_test_access_port_tb.sv
// Testbench for the test access port
`default_nettype none
module jtag_test_access_port_tb
  import tap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, q, q2;
  logic [IR_W-1:0] instr, code;
  logic [31:0] seed = 32'h0000_0023;
  logic [31:0] rd;
  int errors = 0;
  int compares = 0;
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  tap_port u_tap_port (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .instr(instr));
  jtag_tester u_jtag_tester (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Bypass adds one stage that captures zero
  function automatic logic [7:0] exp_bypass(input logic [7:0] d);
    return {d[6:0], 1'b0};
  endfunction : exp_bypass
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++)
      u_jtag_tester.step(seq[i], 1'b0, q, q2);
  endtask : go
  task automatic shift(input int n, input logic [31:0] din);
    rd = '0;
    for (int i = 0; i < n; i++)
    begin
      u_jtag_tester.step(i == n - 1, din[i], rd[i], q2);
      if (i < n - 1)
        chk(32'(q2), 32'(rd[i]));
    end
    u_jtag_tester.step(1'b1, 1'b0, q, q2);
    chk(32'(q), 32'(1'bz));
    go(8'h00, 1);
  endtask : shift
  task automatic ir_load(input logic [IR_W-1:0] c);
    go(8'h03, 4);
    shift(IR_W, 32'(c));
    chk(32'(rd[IR_W-1:0]), 32'(IR_CAPTURE));
    chk(32'(instr), 32'(c));
  endtask : ir_load
  task finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #200000;
    errors++;
    $display("mismatch at %0t: timeout", $time);
    finish_test;
  end
  initial
  begin
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    u_jtag_tester.set_trst(1'b1);
    repeat (8) @(negedge core_clk);
    chk(32'(instr), 32'(INSTR_IDCODE));
    chk(32'(tdo_oe), 32'(1'b0));
    go(8'h00, 1);
    ir_load(INSTR_IDCODE);
    seed = xs(seed);
    go(8'h01, 3);
    shift(ID_W, seed);
    chk(rd, ID_VALUE_DEFAULT);
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      code = (k == 0 || seed[3:0] == INSTR_IDCODE) ? INSTR_BYPASS : seed[3:0];
      ir_load(code);
      go(8'h01, 3);
      shift(8, seed >> 8);
      chk(32'(rd[7:0]), 32'(exp_bypass(seed[15:8])));
    end
    go(8'h1F, 5);
    chk(32'(instr), 32'(INSTR_IDCODE));
    go(8'h00, 1);
    ir_load(INSTR_BYPASS);
    go(8'h01, 5);
    chk(32'(tdo_oe), 32'(1'b1));
    // Reset lands on a falling core clock edge, between rising edges, with the test clock still
    u_jtag_tester.set_trst(1'b0);
    #1;
    chk(32'(tdo_oe), 32'(1'b0));
    chk(32'(instr), 32'(INSTR_IDCODE));
    // Second release mid-run: the port must come back fully usable
    u_jtag_tester.set_trst(1'b1);
    go(8'h00, 1);
    ir_load(INSTR_BYPASS);
    finish_test;
  end
endmodule : jtag_test_access_port_tb
`default_nettype wire
